// [hw/uin_uart_irq.v]
// serial transmitter and receiver with interrupt enable mask and nesting counter
// Summary of operation
// - mask bits: tim1,tim0,rx,tx,modu,sdi,ctrl,dac
// - mask and strobe writes act six cycles later
// - disable strobe write raises nesting count
// - enable strobe lowers count, stops at zero
// - nonzero count blocks all interrupts
// - taking an interrupt raises nesting count
// - five-bit nesting count is software readable
// - idle high, start low, lsb first, stop
// - ten bit periods per byte frame
// - status bits overrun,rxfull,txfull,running at 3..0
// - overrun set on overwrite, cleared by a transfer that does not overwrite
// - rxfull while unread byte is held
// - txfull while a byte waits behind the running frame or both entries are held
// - running while shift register sends frame
// - low read gives byte in 7:0
// - reading received byte clears rxfull
// - receive request on each byte transfer
// - low write queues only bits 7:0
// - idle transmitter loads at once, requests, sends
// - busy transmitter holds byte, txfull set
// - high register uses bits 15:8
// - rate from two cascaded dividers 15:8, 7:0
// - start on falling edge, sample mid-bit
`timescale 1ns/1ns
`include "uin_defs.vh"

module uin_uart_irq (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// processor register bus
	input wire [15:0] busAddr,
	input wire busWrite,
	input wire busRead,
	input wire [15:0] busWdata,
	output reg [15:0] busRdata,
	// other interrupt sources of the controller, one-cycle pulses
	input wire [7:0] otherIrqIn,
	// interrupt to the processor core
	output wire irqTake,
	output reg [7:0] irqVector,
	// serial line
	input wire serialIn,
	output reg serialOut
);

	// ****************************************
	// register bus decode
	// ****************************************

	wire wrEnable = busWrite && (busAddr == `UIN_ADDR_ENABLE);
	wire wrGdis = busWrite && (busAddr == `UIN_ADDR_GDIS);
	wire wrGena = busWrite && (busAddr == `UIN_ADDR_GENA);
	wire wrNest = busWrite && (busAddr == `UIN_ADDR_NEST);
	wire wrLow = busWrite && (busAddr == `UIN_ADDR_BLOW);
	wire wrHigh = busWrite && (busAddr == `UIN_ADDR_BHIGH);
	wire wrDiv = busWrite && (busAddr == `UIN_ADDR_DIV);
	wire rdLow = busRead && (busAddr == `UIN_ADDR_BLOW);
	wire rdHigh = busRead && (busAddr == `UIN_ADDR_BHIGH);

	// ****************************************
	// control write pipeline
	// ****************************************

	reg [7:0] enableMask; // software copy, readable at once
	reg [7:0] enableLive; // copy that gates requests
	reg [7:0] maskPipe [0:5]; // delayed mask values
	reg [5:0] maskVld; // mask write in flight
	reg [5:0] gdisPipe; // disable strobe in flight
	reg [5:0] genaPipe; // enable strobe in flight
	reg [4:0] nestCount; // interrupt nesting counter
	integer i;
	integer j; // loop index of the priority pick, kept apart from the clocked loops

	// delay line for mask and strobes, six stages
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			enableMask <= `UIN_RST_ENABLE;
			enableLive <= `UIN_RST_ENABLE;
			maskVld <= 6'h00;
			gdisPipe <= 6'h00;
			genaPipe <= 6'h00;
			for (i = 0; i < 6; i = i + 1) begin
				maskPipe[i] <= `UIN_RST_ENABLE;
			end
		end else begin
			if (wrEnable) begin
				enableMask <= busWdata[7:0];
			end
			maskPipe[0] <= busWdata[7:0];
			for (i = 1; i < 6; i = i + 1) begin
				maskPipe[i] <= maskPipe[i-1];
			end
			// writes take effect after six cycles
			maskVld <= {maskVld[4:0], wrEnable};
			gdisPipe <= {gdisPipe[4:0], wrGdis};
			genaPipe <= {genaPipe[4:0], wrGena};
			if (maskVld[5]) begin
				enableLive <= maskPipe[5];
			end
		end
	end

	// ****************************************
	// interrupt controller
	// ****************************************

	reg txReq; // transmit request pulse
	reg rxReq; // receive request pulse
	reg [7:0] pendIrq; // latched pending sources
	wire [7:0] srcPulse; // all sources in mask order
	wire [7:0] srcGated; // pending and enabled

	// source positions follow the enable mask
	assign srcPulse = {otherIrqIn[`UIN_EN_TIM1], otherIrqIn[`UIN_EN_TIM0], rxReq, txReq,
		otherIrqIn[`UIN_EN_MODU], otherIrqIn[`UIN_EN_SDI], otherIrqIn[`UIN_EN_CTRL],
		otherIrqIn[`UIN_EN_DAC]};
	// serial requests gated by bits 4 and 5 like the rest
	assign srcGated = pendIrq & enableLive;
	// blocked while the counter is nonzero
	assign irqTake = (nestCount == 5'h00) && (|srcGated);

	// priority pick, highest bit first
	reg [7:0] pick;
	always @* begin
		pick = 8'h00;
		for (j = 0; j < 8; j = j + 1) begin
			if (srcGated[j]) begin
				pick = 8'h00;
				pick[j] = 1'b1;
			end
		end
	end

	// pending bits and nesting counter
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pendIrq <= 8'h00;
			nestCount <= `UIN_RST_NEST;
			irqVector <= 8'h00;
		end else begin
			// a new pulse wins over the clear from being taken
			// masked sources are not latched, so an old event cannot fire later
			pendIrq <= (pendIrq & ~(irqTake ? pick : 8'h00)) | (srcPulse & enableLive);
			if (irqTake) begin
				irqVector <= pick;
			end
			if (wrNest) begin
				nestCount <= busWdata[4:0];
			end else begin
				// taken interrupt and disable strobe each add one
				// enable strobe subtracts one, never below zero
				nestCount <= nestCount + {4'h0, irqTake} + {4'h0, gdisPipe[5]}
					- ((genaPipe[5] && (nestCount != 5'h00 || irqTake || gdisPipe[5]))
					? 5'h01 : 5'h00);
			end
		end
	end

	// ****************************************
	// bit rate dividers
	// ****************************************

	reg [15:0] rateDiv; // first divider 15:8, second 7:0
	reg [7:0] div1Cnt; // first divider counter
	reg [7:0] div2Cnt; // second divider counter
	wire sampleTick = (div1Cnt == rateDiv[15:8]); // receiver sample rate
	reg bitTick; // one pulse per bit period

	// cascade of two dividers
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rateDiv <= `UIN_RST_DIV;
			div1Cnt <= 8'h00;
			div2Cnt <= 8'h00;
			bitTick <= 1'b0;
		end else begin
			if (wrDiv) begin
				rateDiv <= busWdata;
			end
			bitTick <= 1'b0;
			div1Cnt <= sampleTick ? 8'h00 : div1Cnt + 8'h01;
			if (sampleTick) begin
				// a zero second divider relies on software setting 6..255
				if (div2Cnt + 8'h01 >= rateDiv[7:0]) begin
					div2Cnt <= 8'h00;
					bitTick <= 1'b1;
				end else begin
					div2Cnt <= div2Cnt + 8'h01;
				end
			end
		end
	end

	// ****************************************
	// two-entry transmit buffer and transmitter
	// ****************************************

	reg [7:0] bufMem [0:1]; // holding entries
	reg bufWp; // write pointer
	reg bufRp; // read pointer
	reg [1:0] bufCnt; // entries held
	wire bufInValid = wrLow || wrHigh;
	wire [7:0] bufInData = wrHigh ? busWdata[15:8] : busWdata[7:0];
	wire bufInReady = (bufCnt != 2'h2);
	wire bufOutValid = (bufCnt != 2'h0);
	reg txRun; // shift register busy
	wire bufOutReady = !txRun;
	wire bufPush = bufInValid && bufInReady;
	wire bufPop = bufOutValid && bufOutReady;
	reg [9:0] txShift; // frame being sent
	reg [3:0] txBits; // bit periods left
	wire txFullFlag = !bufInReady || (txRun && bufOutValid); // byte waiting or no room

	// buffer bookkeeping; a write while full is dropped
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bufWp <= 1'b0;
			bufRp <= 1'b0;
			bufCnt <= 2'h0;
			bufMem[0] <= `UIN_RST_BYTE;
			bufMem[1] <= `UIN_RST_BYTE;
		end else begin
			if (bufPush) begin
				bufMem[bufWp] <= bufInData;
				bufWp <= ~bufWp;
			end
			if (bufPop) begin
				bufRp <= ~bufRp;
			end
			bufCnt <= bufCnt + {1'b0, bufPush} - {1'b0, bufPop};
		end
	end

	// transmit shifter: loads when idle, ten periods per frame
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txRun <= 1'b0;
			txShift <= 10'h3ff;
			txBits <= 4'h0;
			txReq <= 1'b0;
			serialOut <= 1'b1;
		end else begin
			txReq <= 1'b0;
			if (bufPop) begin
				// stop, data lsb first, start
				txShift <= {1'b1, bufMem[bufRp], 1'b0};
				txBits <= `UIN_FRAME_BITS;
				txRun <= 1'b1;
				txReq <= 1'b1;
			end else if (txRun && bitTick && txBits == 4'h0) begin
				// stop bit has had its full period, frame done
				txRun <= 1'b0;
			end else if (txRun && bitTick) begin
				serialOut <= txShift[0];
				txShift <= {1'b1, txShift[9:1]};
				txBits <= txBits - 4'h1;
			end
			if (!txRun) begin
				serialOut <= 1'b1;
			end
		end
	end

	// ****************************************
	// receiver
	// ****************************************

	localparam RX_IDLE = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_DATA = 2'h2;
	localparam RX_STOP = 2'h3;

	reg rxMeta; // first synchroniser stage
	reg rxSync; // second synchroniser stage
	reg rxPrev; // previous synchronised level
	reg [1:0] rxState; // receive state
	reg [7:0] rxSampCnt; // sample ticks within a bit
	reg [2:0] rxBitIdx; // data bit index
	reg [7:0] rxShift; // receive shift register
	reg [7:0] rxData; // receive data register
	reg rxFull; // unread byte held
	reg rxOrun; // last transfer overwrote
	wire rxMid = sampleTick && (rxSampCnt == {1'b0, rateDiv[7:1]});
	wire rxEnd = sampleTick && (rxSampCnt + 8'h01 >= rateDiv[7:0]);

	// line synchroniser
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
			rxPrev <= 1'b1;
		end else begin
			rxMeta <= serialIn;
			rxSync <= rxMeta;
			rxPrev <= rxSync;
		end
	end

	// framing state machine
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxState <= RX_IDLE;
			rxSampCnt <= 8'h00;
			rxBitIdx <= 3'h0;
			rxShift <= 8'h00;
			rxData <= `UIN_RST_BYTE;
			rxFull <= 1'b0;
			rxOrun <= 1'b0;
			rxReq <= 1'b0;
		end else begin
			rxReq <= 1'b0;
			if (sampleTick) begin
				rxSampCnt <= rxEnd ? 8'h00 : rxSampCnt + 8'h01;
			end
			// reading the byte clears the full flag
			if (rdLow || rdHigh) begin
				rxFull <= 1'b0;
			end
			case (rxState)
			RX_IDLE: begin
				// falling edge marks a start bit
				if (rxPrev && !rxSync) begin
					rxState <= RX_START;
					rxSampCnt <= 8'h00;
				end
			end
			RX_START: begin
				if (rxMid) begin
					rxState <= rxSync ? RX_IDLE : RX_DATA;
					rxBitIdx <= 3'h0;
				end
			end
			RX_DATA: begin
				// mid-bit sample, lsb first
				if (rxMid) begin
					rxShift <= {rxSync, rxShift[7:1]};
					rxBitIdx <= rxBitIdx + 3'h1;
					if (rxBitIdx == 3'h7) begin
						rxState <= RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rxMid) begin
					rxState <= RX_IDLE;
					if (rxSync) begin
						// transfer sets full; overrun gets old full and not a read in this cycle
						rxData <= rxShift;
						rxFull <= 1'b1;
						rxOrun <= rxFull && !(rdLow || rdHigh);
						rxReq <= 1'b1;
					end
				end
			end
			default: begin
				rxState <= RX_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// read data
	// ****************************************

	// read multiplexer, unmapped addresses read zero
	always @* begin
		case (busAddr)
		`UIN_ADDR_ENABLE: busRdata = {8'h00, enableMask};
		`UIN_ADDR_NEST: busRdata = {11'h000, nestCount};
		// status layout
		`UIN_ADDR_STATUS: busRdata = {12'h000, rxOrun, rxFull, txFullFlag, txRun};
		`UIN_ADDR_BLOW: busRdata = {8'h00, rxData};
		`UIN_ADDR_BHIGH: busRdata = {rxData, 8'h00};
		`UIN_ADDR_DIV: busRdata = rateDiv;
		default: busRdata = 16'h0000;
		endcase
	end

endmodule

// [hw/uin_defs.vh]
// register offsets, field positions, reset values and timing counts of the serial port block
`ifndef UIN_DEFS_VH
`define UIN_DEFS_VH

// register addresses on the processor data bus
`define UIN_ADDR_ENABLE 16'hc01a
`define UIN_ADDR_GDIS 16'hc01b
`define UIN_ADDR_GENA 16'hc01c
`define UIN_ADDR_NEST 16'hc01d
`define UIN_ADDR_STATUS 16'hc028
`define UIN_ADDR_BLOW 16'hc029
`define UIN_ADDR_BHIGH 16'hc02a
`define UIN_ADDR_DIV 16'hc02b

// enable mask bit positions
`define UIN_EN_TIM1 7
`define UIN_EN_TIM0 6
`define UIN_EN_RX 5
`define UIN_EN_TX 4
`define UIN_EN_MODU 3
`define UIN_EN_SDI 2
`define UIN_EN_CTRL 1
`define UIN_EN_DAC 0

// status bit positions
`define UIN_ST_ORUN 3
`define UIN_ST_RXFULL 2
`define UIN_ST_TXFULL 1
`define UIN_ST_TXRUN 0

// reset values
`define UIN_RST_ENABLE 8'h00
`define UIN_RST_NEST 5'h00
`define UIN_RST_DIV 16'h0000
`define UIN_RST_BYTE 8'h00

// latency of mask and strobe writes, in cycles (at most six)
`define UIN_CTRL_DELAY 3'h6
// frame length in bit periods
`define UIN_FRAME_BITS 4'ha

`endif

// [test/uin_uart_irq_props.sv]
// concurrent checks on the ports of the serial port block
`timescale 1ns/1ns
`include "uin_defs.vh"

module uin_uart_irq_props (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// register bus
	input wire [15:0] busAddr,
	input wire busWrite,
	input wire busRead,
	input wire [15:0] busWdata,
	input wire [15:0] busRdata,
	// interrupts
	input wire [7:0] otherIrqIn,
	input wire irqTake,
	input wire [7:0] irqVector,
	// serial line
	input wire serialIn,
	input wire serialOut
);
	// ****
	// checks
	// ****
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	low_upper_zero_a: assert property (busAddr == `UIN_ADDR_BLOW |-> busRdata[15:8] == 8'h00)
		else $error("low data read has upper bits set");
	high_lower_zero_a: assert property (busAddr == `UIN_ADDR_BHIGH |-> busRdata[7:0] == 8'h00)
		else $error("high data read has lower bits set");
	status_width_a: assert property (busAddr == `UIN_ADDR_STATUS |-> busRdata[15:4] == 12'h000)
		else $error("status read wider than four bits");
	idle_line_a: assert property (busAddr == `UIN_ADDR_STATUS && !busRdata[0] |-> serialOut)
		else $error("line low while transmitter idle");
	full_running_a: assert property (busAddr == `UIN_ADDR_STATUS && busRdata[1] |-> busRdata[0])
		else $error("transmit full without running");
	take_onehot_a: assert property (irqTake |=> $onehot(irqVector))
		else $error("vector not one-hot after take");
	count_blocks_a: assert property (busAddr == `UIN_ADDR_NEST && busRdata[4:0] != 5'h00 |-> !irqTake)
		else $error("interrupt taken with nonzero count");
	take_counts_a: assert property ((irqTake && busAddr == `UIN_ADDR_NEST && !busWrite) ##1
		busAddr == `UIN_ADDR_NEST |-> busRdata[4:0] == $past(busRdata[4:0]) + 5'h01)
		else $error("take did not raise count");
	disable_delay_a: assert property (busWrite && busAddr == `UIN_ADDR_GDIS |-> ##7 (!irqTake)[*3])
		else $error("disable write did not block");

	// main scenarios seen
	cover property (irqTake);
	cover property (busAddr == `UIN_ADDR_STATUS && busRdata[3]);
	cover property ($fell(serialIn));
endmodule

bind uin_uart_irq uin_uart_irq_props uin_uart_irq_props_inst (.ref_clk(ref_clk), .nrst(nrst),
	.busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata),
	.busRdata(busRdata), .otherIrqIn(otherIrqIn), .irqTake(irqTake), .irqVector(irqVector),
	.serialIn(serialIn), .serialOut(serialOut));

// [test/uin_serial_host.sv]
// remote serial terminal model driving and watching the line
`timescale 1ns/1ns

module uin_serial_host #(
	parameter int BITCLK = 16
) (
	// clock
	input wire logic ref_clk,
	// line from and to the device
	input wire logic lineIn,
	output logic lineOut
);
	logic [7:0] gotQ[$]; // bytes whose stop bit was high, bad start included
	int badFrames = 0; // frames with bad start or stop

	initial lineOut = 1'b1; // idle high

	// send start, eight data lsb first, stop
	task automatic sendByte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge ref_clk);
			lineOut = f[i];
			repeat (BITCLK - 1) @(negedge ref_clk);
		end
	endtask

	// find start edge, sample each bit mid-period
	initial begin
		logic [7:0] d;
		forever begin
			@(negedge lineIn);
			repeat (BITCLK / 2) @(posedge ref_clk);
			if (lineIn !== 1'b0) badFrames++;
			for (int i = 0; i < 9; i++) begin
				repeat (BITCLK) @(posedge ref_clk);
				if (i < 8) d[i] = lineIn;
			end
			if (lineIn === 1'b1) gotQ.push_back(d);
			else badFrames++;
		end
	end
endmodule

// [test/uin_uart_irq_test.sv]
// self-checking bench for the serial port block with interrupt nesting
`timescale 1ns/1ns
`include "uin_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end

module uin_uart_irq_test;
	localparam int BITCLK = 16; // divider 16'h0108 gives (1+1)*8 clocks
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] busAddr = 16'h0000;
	logic busWrite = 1'b0;
	logic busRead = 1'b0;
	logic [15:0] busWdata = 16'h0000;
	logic [7:0] otherIrqIn = 8'h00;
	logic [15:0] busRdata;
	logic irqTake;
	logic [7:0] irqVector;
	logic serialIn;
	logic serialOut;
	int errors = 0;
	int cmp_count = 0;
	logic [15:0] regs [6] = '{16'hc01a, 16'hc01d, 16'hc028, 16'hc029, 16'hc02b, 16'hc030};

	uin_uart_irq uin_uart_irq_inst (.ref_clk(ref_clk), .nrst(nrst), .busAddr(busAddr),
		.busWrite(busWrite), .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
		.otherIrqIn(otherIrqIn), .irqTake(irqTake), .irqVector(irqVector),
		.serialIn(serialIn), .serialOut(serialOut));
	uin_serial_host #(.BITCLK(BITCLK)) uin_serial_host_inst (.ref_clk(ref_clk),
		.lineIn(serialOut), .lineOut(serialIn));

	initial forever #4 ref_clk = ~ref_clk;

	// ****
	// tasks
	// ****
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		busAddr = a;
		busWdata = d;
		busWrite = 1'b1;
		@(negedge ref_clk);
		busWrite = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(negedge ref_clk);
		busAddr = a;
		busRead = 1'b1;
		#1;
		`CHK(busRdata, e)
		@(negedge ref_clk);
		busRead = 1'b0;
	endtask

	task automatic summarize;
		$display("Checks %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// bounded wait: 0 status bits, 1 take, 2 received count
	task automatic waitOn(input int kind, input logic [15:0] m);
		int n;
		bit ok;
		n = 0;
		busAddr = kind == 0 ? `UIN_ADDR_STATUS : `UIN_ADDR_NEST;
		ok = 0;
		while (!ok && n < 3000) begin
			@(negedge ref_clk);
			ok = kind == 0 ? (busRdata & m) === m : kind == 1 ? irqTake === 1'b1 :
				uin_serial_host_inst.gotQ.size() >= m;
			n++;
		end
		if (!ok) begin
			errors++;
			$display("Error at %0t: wait ran out", $time);
			summarize();
		end
	endtask

	// ****
	// tests
	// ****
	initial begin
		repeat (10) @(negedge ref_clk);
		nrst = 1'b1;
		foreach (regs[i]) rd(regs[i], 16'h0000);
		wr(`UIN_ADDR_DIV, 16'h0108);
		rd(`UIN_ADDR_DIV, 16'h0108);
		wr(`UIN_ADDR_ENABLE, 16'h12a5);
		rd(`UIN_ADDR_ENABLE, 16'h00a5);
		wr(`UIN_ADDR_ENABLE, 16'h0000);
		wr(`UIN_ADDR_NEST, 16'hffe3);
		rd(`UIN_ADDR_NEST, 16'h0003);
		wr(`UIN_ADDR_NEST, 16'h0000);
		rd(`UIN_ADDR_NEST, 16'h0000);
		$display("Test done: registers");
		wr(`UIN_ADDR_BLOW, 16'hab5a);
		wr(`UIN_ADDR_BHIGH, 16'h3cc3);
		repeat (BITCLK) @(negedge ref_clk);
		rd(`UIN_ADDR_STATUS, 16'h0003);
		waitOn(2, 16'h0002);
		`CHK(uin_serial_host_inst.gotQ.pop_front(), 8'h5a)
		`CHK(uin_serial_host_inst.gotQ.pop_front(), 8'h3c)
		repeat (BITCLK) @(negedge ref_clk);
		rd(`UIN_ADDR_STATUS, 16'h0000);
		$display("Test done: transmit");
		uin_serial_host_inst.sendByte(8'h96);
		waitOn(0, 16'h0004);
		rd(`UIN_ADDR_STATUS, 16'h0004);
		rd(`UIN_ADDR_BLOW, 16'h0096);
		rd(`UIN_ADDR_STATUS, 16'h0000);
		uin_serial_host_inst.sendByte(8'h11);
		uin_serial_host_inst.sendByte(8'h22);
		repeat (4) @(negedge ref_clk);
		rd(`UIN_ADDR_STATUS, 16'h000c);
		rd(`UIN_ADDR_BHIGH, 16'h2200);
		uin_serial_host_inst.sendByte(8'h33);
		repeat (4) @(negedge ref_clk);
		rd(`UIN_ADDR_STATUS, 16'h0004);
		rd(`UIN_ADDR_BLOW, 16'h0033);
		$display("Test done: receive");
		wr(`UIN_ADDR_ENABLE, 16'h0020);
		fork
			uin_serial_host_inst.sendByte(8'h77);
		join_none
		waitOn(1, 16'h0000);
		@(posedge ref_clk);
		#1;
		`CHK(irqVector, 8'h20)
		rd(`UIN_ADDR_NEST, 16'h0001);
		waitOn(0, 16'h0004);
		rd(`UIN_ADDR_BLOW, 16'h0077);
		wr(`UIN_ADDR_ENABLE, 16'h0080);
		wr(`UIN_ADDR_GENA, 16'h5555);
		repeat (8) @(negedge ref_clk);
		rd(`UIN_ADDR_NEST, 16'h0000);
		wr(`UIN_ADDR_GENA, 16'h0000);
		repeat (8) @(negedge ref_clk);
		rd(`UIN_ADDR_NEST, 16'h0000);
		wr(`UIN_ADDR_GDIS, 16'h1234);
		repeat (8) @(negedge ref_clk);
		rd(`UIN_ADDR_NEST, 16'h0001);
		otherIrqIn = 8'h80;
		@(negedge ref_clk);
		otherIrqIn = 8'h00;
		repeat (8) begin
			@(negedge ref_clk);
			`CHK(irqTake, 1'b0)
		end
		wr(`UIN_ADDR_GENA, 16'h0000);
		waitOn(1, 16'h0000);
		@(posedge ref_clk);
		#1;
		`CHK(irqVector, 8'h80)
		wr(`UIN_ADDR_GENA, 16'h0000);
		wr(`UIN_ADDR_ENABLE, 16'h0010);
		repeat (8) @(negedge ref_clk);
		wr(`UIN_ADDR_BLOW, 16'h0081);
		waitOn(1, 16'h0000);
		@(posedge ref_clk);
		#1;
		`CHK(irqVector, 8'h10)
		rd(`UIN_ADDR_NEST, 16'h0001);
		waitOn(2, 16'h0001);
		`CHK(uin_serial_host_inst.gotQ.pop_front(), 8'h81)
		`CHK(uin_serial_host_inst.badFrames, 0)
		$display("Test done: interrupts");
		summarize();
	end
endmodule
